// File: core/ssoc_fifo.sv
/*
  synchronous FIFO with valid/ready on both sides; width and depth are parameters.
  assumes one clock domain and a power-of-two depth.
*/
module ssoc_fifo #(
  parameter int unsigned WIDTH = 40,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic clk_sys_i,
  input  wire logic rstn_i,
  ssoc_stream_if.dst in_s,
  ssoc_stream_if.src out_s
);
  localparam int unsigned AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fifo depth must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wptr;
  logic [AW:0]      rptr;
  logic [AW:0]      next_wptr;
  logic [AW:0]      next_rptr;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  assign full        = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
  assign empty       = (wptr == rptr);
  assign in_s.ready  = !full;
  assign out_s.valid = !empty;
  assign out_s.data  = mem[rptr[AW-1:0]];
  assign push        = in_s.valid && !full;
  assign pop         = out_s.ready && !empty;

  always_comb begin
    next_wptr = push ? wptr + 1'b1 : wptr;
    next_rptr = pop ? rptr + 1'b1 : rptr;
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem[wptr[AW-1:0]] <= in_s.data;
    end
  end

  property p_no_overflow;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      full && !pop |=> full;
  endproperty
  a_no_overflow: assert property (p_no_overflow) else $error("fifo left full without a pop");
endmodule // ssoc_fifo

// File: core/ssoc_pkg.sv
/*
  shared constants and types for the select/output control block.
  assumes a single 50 MHz system clock and an active-low asynchronous reset.
*/
package ssoc_pkg;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned LANES       = 4;
  localparam int unsigned LANE_W      = 8;
  localparam int unsigned FIFO_DEPTH  = 16;
  localparam int unsigned CLK_MHZ     = 50;
  localparam logic        MODE_RESET  = 1'b1;
  localparam logic [3:0]  LANES_OFF   = 4'hF;

  typedef enum logic [3:0] {
    SSOC_DESEL  = 4'h1,
    SSOC_WAKE   = 4'h2,
    SSOC_READ   = 4'h4,
    SSOC_WRDATA = 4'h8
  } ssoc_state_t;
endpackage : ssoc_pkg

// File: core/ssoc_stream_if.sv
/*
  valid/ready stream carrying captured write words (data, parity, lane mask).
  assumes producer and consumer share clk_sys_i.
*/
interface ssoc_stream_if #(
  parameter int unsigned W = 40
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface : ssoc_stream_if

// File: core/ssoc_top.sv
/*
  chip-select decode, clock qualify, data/parity direction and burst-order strap
  of a pipelined synchronous sram, with a 16-word write-data fifo toward the core.
  assumes the memory core answers read_data_i one qualified edge after a read is
  issued, and that pins are asynchronous to clk_sys_i (double-synchronised).
*/
// What this block does
// (RULE_01) selected only when a low, b high, c low
// (RULE_02) output gate low lets data and parity drive
// (RULE_03) write data, wake cycle, deselect force high impedance
// (RULE_04) qualifier high freezes all state that edge
// (RULE_05) qualifier alone never changes select state
// (RULE_06) input data captured into register on edge
// (RULE_07) outputs show data of previously captured read
// (RULE_08) parity lines follow data lines in everything
// (RULE_09) parity bit n written only under select n
// (RULE_10) strap high interleaved, low linear burst order
// (RULE_11) floating strap reads as high, interleaved
// (RULE_12) system keeps strap fixed during operation
// (RULE_13) byte select n gates data byte n
// (RULE_14) outputs float one edge after deselect edge
// (RULE_15) drivers on only gate low, read pending, unmasked
module ssoc_top #(
  parameter int unsigned DATA_W = ssoc_pkg::DATA_W,
  parameter int unsigned DEPTH  = ssoc_pkg::FIFO_DEPTH
) (
  input  wire logic              clk_sys_i,
  input  wire logic              rstn_i,
  input  wire logic              select_a_low_i,
  input  wire logic              select_b_high_i,
  input  wire logic              select_c_low_i,
  input  wire logic              edge_qualifier_n_i,
  input  wire logic              write_n_i,
  input  wire logic              output_gate_n_i,
  input  wire logic [3:0]        byte_lane_write_select_n_i,
  input  wire logic              burst_order_i,
  input  wire logic              burst_order_driven_i,
  input  wire logic [DATA_W-1:0] data_i,
  output logic      [DATA_W-1:0] data_o,
  output logic                   data_oe_o,
  input  wire logic [3:0]        parity_lines_i,
  output logic      [3:0]        parity_lines_o,
  output logic                   parity_lines_oe_o,
  input  wire logic [DATA_W+3:0] read_data_i,
  output logic                   read_issue_o,
  output logic                   interleaved_o,
  output logic                   wr_valid_o,
  input  wire logic              wr_ready_i,
  output logic      [DATA_W+7:0] wr_word_o,
  output logic                   wr_stall_o
);
  localparam int unsigned WW = DATA_W + 8;

  initial begin
    if (DATA_W != ssoc_pkg::LANES * ssoc_pkg::LANE_W) $error("data width must be four lanes");
  end

  // two-flop synchronisers; stage one is read only by stage two
  localparam int unsigned SW = 8 + DATA_W + 4 + 4;
  logic [SW-1:0] pin_meta;
  logic [SW-1:0] pin_sync;
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_meta <= {SW{1'b1}};
      pin_sync <= {SW{1'b1}};
    end else begin
      pin_meta <= {select_a_low_i, select_b_high_i, select_c_low_i, edge_qualifier_n_i,
                   write_n_i, output_gate_n_i, burst_order_i, burst_order_driven_i,
                   data_i, parity_lines_i, byte_lane_write_select_n_i};
      pin_sync <= pin_meta;
    end
  end

  logic              s_a_n;
  logic              s_b;
  logic              s_c_n;
  logic              s_qual_n;
  logic              s_we_n;
  logic              s_gate_n;
  logic              s_mode;
  logic              s_mode_drv;
  logic [DATA_W-1:0] s_data;
  logic [3:0]        s_par;
  logic [3:0]        s_lane_n;
  assign {s_a_n, s_b, s_c_n, s_qual_n, s_we_n, s_gate_n, s_mode, s_mode_drv,
          s_data, s_par, s_lane_n} = pin_sync;

  function automatic logic is_selected(input logic a_n, input logic b, input logic c_n);
    return !a_n && b && !c_n;  // [RULE_01]
  endfunction

  // lane mask expanded to bits, used for the data bytes only; parity uses the inverted mask directly
  function automatic logic [DATA_W-1:0] lane_bits(input logic [3:0] sel_n);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{!sel_n[i]}};  // [RULE_13]
    end
    return m;
  endfunction

  logic qual;
  assign qual = !s_qual_n;

  ssoc_pkg::ssoc_state_t state;
  ssoc_pkg::ssoc_state_t next_state;
  logic              mode;
  logic              next_mode;
  logic [DATA_W-1:0] in_data;
  logic [DATA_W-1:0] next_in_data;
  logic [3:0]        in_par;
  logic [3:0]        next_in_par;
  logic [3:0]        wr_mask_n;
  logic [3:0]        next_wr_mask_n;
  logic [3:0]        in_mask_n;
  logic [3:0]        next_in_mask_n;
  logic [DATA_W-1:0] out_data;
  logic [DATA_W-1:0] next_out_data;
  logic [3:0]        out_par;
  logic [3:0]        next_out_par;
  logic              push;
  logic              next_push;
  logic              rd_pend;
  logic              next_rd_pend;
  logic              drive;
  logic              sel;
  logic              fifo_ready;

  assign sel = is_selected(s_a_n, s_b, s_c_n);

  always_comb begin
    next_state     = state;
    next_mode      = mode;
    next_in_data   = in_data;
    next_in_par    = in_par;
    next_wr_mask_n = wr_mask_n;
    next_out_data  = out_data;
    next_out_par   = out_par;
    next_in_mask_n = in_mask_n;
    next_rd_pend   = rd_pend;
    // a refused word stays offered; dropping it would lose write data
    next_push      = push && !wr_in.ready;
    // frozen edge: every register but push holds, selection included; push still clears once the fifo takes the word [RULE_04] [RULE_05]
    if (qual && fifo_ready) begin
      next_mode    = s_mode_drv ? s_mode : 1'b1;  // [RULE_10] [RULE_11]
      // read data is loaded, and pending, one edge after the read command
      next_rd_pend = (state == ssoc_pkg::SSOC_READ);  // [RULE_14] [RULE_15]
      if (state == ssoc_pkg::SSOC_WRDATA) begin
        next_in_data   = s_data;     // [RULE_06]
        next_in_par    = s_par;      // [RULE_08]
        // lanes of the command that owns this data, not those of the next command
        next_in_mask_n = wr_mask_n;  // [RULE_09] [RULE_13]
        next_push      = 1'b1;
      end
      if (state == ssoc_pkg::SSOC_READ) begin
        next_out_data = read_data_i[DATA_W+3:4];  // [RULE_07]
        next_out_par  = read_data_i[3:0];         // [RULE_08]
      end
      case (state)
        ssoc_pkg::SSOC_DESEL: begin
          next_state = sel ? ssoc_pkg::SSOC_WAKE : ssoc_pkg::SSOC_DESEL;
        end
        ssoc_pkg::SSOC_WAKE,
        ssoc_pkg::SSOC_READ,
        ssoc_pkg::SSOC_WRDATA: begin
          if (!sel) begin
            next_state = ssoc_pkg::SSOC_DESEL;  // [RULE_14]
          end else if (!s_we_n) begin
            next_state     = ssoc_pkg::SSOC_WRDATA;
            next_wr_mask_n = s_lane_n;  // [RULE_09] [RULE_13]
          end else begin
            next_state = ssoc_pkg::SSOC_READ;
          end
        end
        default: begin
          next_state = ssoc_pkg::SSOC_DESEL;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state     <= ssoc_pkg::SSOC_DESEL;
      mode      <= ssoc_pkg::MODE_RESET;
      in_data   <= '0;
      in_par    <= '0;
      wr_mask_n <= ssoc_pkg::LANES_OFF;
      in_mask_n <= ssoc_pkg::LANES_OFF;
      out_data  <= '0;
      out_par   <= '0;
      push      <= 1'b0;
      rd_pend   <= 1'b0;
    end else begin
      state     <= next_state;
      mode      <= next_mode;
      in_data   <= next_in_data;
      in_par    <= next_in_par;
      wr_mask_n <= next_wr_mask_n;
      in_mask_n <= next_in_mask_n;
      out_data  <= next_out_data;
      out_par   <= next_out_par;
      push      <= next_push;
      rd_pend   <= next_rd_pend;
    end
  end

  // pending read data drives while the gate is low; a write data phase masks it, and wake
  // carries none, while a read before deselect stays pending one edge, so the float after deselect lags one edge
  assign drive = !s_gate_n && rd_pend && (state != ssoc_pkg::SSOC_WRDATA);  // [RULE_02] [RULE_03]

  assign data_o            = out_data;
  assign parity_lines_o    = out_par;
  assign data_oe_o         = drive;  // [RULE_15]
  assign parity_lines_oe_o = drive;  // [RULE_08]
  assign interleaved_o     = mode;
  assign read_issue_o      = qual && fifo_ready && sel && s_we_n && (state != ssoc_pkg::SSOC_DESEL);

  // write word: data bytes masked by lane, parity masked by lane; fifo back-pressure
  // stalls the whole block, traded against losing write data
  ssoc_stream_if #(.W(WW)) wr_in ();
  ssoc_stream_if #(.W(WW)) wr_out ();

  assign wr_in.valid   = push;
  assign wr_in.data    = {in_data & lane_bits(in_mask_n),
                          in_par & ~in_mask_n,
                          in_mask_n};  // [RULE_09]
  assign fifo_ready    = !(push && !wr_in.ready);
  assign wr_stall_o    = !fifo_ready;
  assign wr_valid_o    = wr_out.valid;
  assign wr_word_o     = wr_out.data;
  assign wr_out.ready  = wr_ready_i;

  ssoc_fifo #(
    .WIDTH (WW),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .in_s      (wr_in),
    .out_s     (wr_out)
  );

  property p_sel_decode;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (state == ssoc_pkg::SSOC_DESEL) && qual && fifo_ready && sel
        |=> state == ssoc_pkg::SSOC_WAKE;
  endproperty
  a_sel_decode: assert property (p_sel_decode) // [RULE_01]
    else $error("select decode not honoured");

  property p_gate_drives;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      rd_pend && (state != ssoc_pkg::SSOC_WRDATA) && !s_gate_n
        |-> data_oe_o && parity_lines_oe_o;
  endproperty
  a_gate_drives: assert property (p_gate_drives) // [RULE_02]
    else $error("gate low but no drive");

  property p_mask;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (state == ssoc_pkg::SSOC_WRDATA) || (state == ssoc_pkg::SSOC_WAKE) || !rd_pend
        |-> !data_oe_o;
  endproperty
  a_mask: assert property (p_mask) // [RULE_03]
    else $error("driving during masked cycle");

  property p_freeze;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      !qual |=> state == $past(state) && out_data == $past(out_data)
                && (!push || $past(push));
  endproperty
  a_freeze: assert property (p_freeze) // [RULE_04]
    else $error("state moved on unqualified edge");

  property p_qual_no_desel;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      !qual && (state == ssoc_pkg::SSOC_READ) |=> state == ssoc_pkg::SSOC_READ;
  endproperty
  a_qual_no_desel: assert property (p_qual_no_desel) // [RULE_05]
    else $error("qualifier changed select");

  property p_capture;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (state == ssoc_pkg::SSOC_WRDATA) && qual && fifo_ready
        |=> push && in_data == $past(s_data);
  endproperty
  a_capture: assert property (p_capture) // [RULE_06]
    else $error("write data not captured");

  property p_stall_hold;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      push && !wr_in.ready |=> push && $stable(in_data) && $stable(in_mask_n);
  endproperty
  a_stall_hold: assert property (p_stall_hold) // [RULE_06]
    else $error("refused write word not held");

  property p_read_out;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (state == ssoc_pkg::SSOC_READ) && qual && fifo_ready
        |=> out_data == $past(read_data_i[DATA_W+3:4]);
  endproperty
  a_read_out: assert property (p_read_out) // [RULE_07]
    else $error("read data not loaded");

  property p_par_follow;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      data_oe_o == parity_lines_oe_o;
  endproperty
  a_par_follow: assert property (p_par_follow) // [RULE_08]
    else $error("parity direction differs");

  property p_mode;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      qual && fifo_ready && !s_mode_drv |=> interleaved_o;
  endproperty
  a_mode: assert property (p_mode) // [RULE_11]
    else $error("floating strap not interleaved");

  // the read taken before the deselect edge still drives for one cycle
  property p_desel_pipe;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (state == ssoc_pkg::SSOC_READ) && qual && fifo_ready && !sel
        |=> data_oe_o == !s_gate_n;
  endproperty
  a_desel_pipe: assert property (p_desel_pipe) // [RULE_14]
    else $error("deselect float not pipelined");

  property p_desel_float;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (state == ssoc_pkg::SSOC_DESEL) && qual && fifo_ready
        |=> !data_oe_o && !parity_lines_oe_o;
  endproperty
  a_desel_float: assert property (p_desel_float) // [RULE_14]
    else $error("outputs driven while deselected");
endmodule // ssoc_top

// File: tb/ssoc_core_model.sv
/*
  behavioural memory core behind the select/output block: answers each accepted
  read with a fresh random word {data32, parity4} one edge later.
  assumes read_issue_o is high on every edge that issues a read and read_data_i is sampled the edge after.
*/
module ssoc_core_model (
  input  wire logic        clk_sys_i,
  input  wire logic        read_issue_i,
  output logic      [35:0] read_data_o,
  output logic      [35:0] held_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    read_data_o = 36'h0;
    held_o      = 36'h0;
  end
  always @(posedge clk_sys_i) begin
    held_o      <= read_data_o;
    // idle edges show the inverse so a stale word cannot pass for a fresh one
    read_data_o <= read_issue_i ? 36'({$urandom, $urandom}) : ~read_data_o;
  end
endmodule // ssoc_core_model

// File: tb/tb.sv
/*
  self-checking bench for ssoc_top: strap, select decode, reads, freeze,
  gate, deselect and lane-masked writes through the fifo with back-pressure.
  assumes pin inputs take effect about two edges after change (sync flops).
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_i = 1'b0;
  logic        rstn_i    = 1'b0;
  logic        sa, sb, sc, qn, wn, gn, bo, bod, rdy;
  logic [3:0]  bw, pin, par_o;
  logic [31:0] din, dout, m;
  logic        doe, poe, issue, ilv, wval, stall;
  logic [35:0] rd, held;
  logic [39:0] wword, exp;
  logic [31:0] keep;
  int          bad_count = 0;
  int          n_checks  = 0;
  int          i, k, r, hits, idle, popped;

  ssoc_top dut_u (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .select_a_low_i(sa), .select_b_high_i(sb),
    .select_c_low_i(sc), .edge_qualifier_n_i(qn), .write_n_i(wn), .output_gate_n_i(gn),
    .byte_lane_write_select_n_i(bw), .burst_order_i(bo), .burst_order_driven_i(bod),
    .data_i(din), .data_o(dout), .data_oe_o(doe), .parity_lines_i(pin),
    .parity_lines_o(par_o), .parity_lines_oe_o(poe), .read_data_i(rd),
    .read_issue_o(issue), .interleaved_o(ilv), .wr_valid_o(wval), .wr_ready_i(rdy),
    .wr_word_o(wword), .wr_stall_o(stall)
  );
  ssoc_core_model core_u (.clk_sys_i(clk_sys_i), .read_issue_i(issue), .read_data_o(rd),
                          .held_o(held));

  initial begin
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input logic [39:0] seen, input logic [39:0] expv);
    n_checks++;
    if (seen !== expv) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask

  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic timeout();
    chk(40'h1, 40'h0);
    finish_test();
  endtask

  initial begin
    {sa, sb, sc, qn, wn, gn, bo, bod, rdy} = 9'b100_0_1_0_1_1_0;
    bw  = 4'hF;
    din = 32'h0;
    pin = 4'h0;
    void'($urandom(32'h9595));
    cyc(3);
    rstn_i = 1'b1;
    chk(doe, 1'b0);
    chk(ilv, 1'b1);
    chk(wval, 1'b0);
    // strap moved only while deselected
    for (k = 0; k < 4; k++) begin
      {bod, bo} = 2'(k);
      cyc(5);
      chk(ilv, !bod || bo);
    end
    $display("END strap");
    for (k = 0; k < 8; k++) begin
      {sa, sb, sc} = 3'(k);
      hits = 0;
      cyc(5);
      repeat (6) begin
        @(negedge clk_sys_i);
        hits += (issue === 1'b1);
        if (k != 2) chk(doe, 1'b0);
      end
      chk(hits != 0, k == 2);
    end
    $display("END decode");
    {sa, sb, sc} = 3'b010;
    for (i = 0; i < 20 && issue !== 1'b1; i++) begin
      @(negedge clk_sys_i);
      chk(doe, 1'b0);
    end
    if (i == 20) timeout();
    cyc(2);
    repeat (8) begin
      @(negedge clk_sys_i);
      chk(doe, 1'b1);
      chk({4'h0, dout, par_o}, {4'h0, held});
    end
    $display("END read");
    qn = 1'b1;
    cyc(4);
    keep = dout;
    repeat (6) begin
      @(negedge clk_sys_i);
      chk(issue, 1'b0);
      chk({8'h00, dout}, {8'h00, keep});
      chk(doe, 1'b1);
    end
    qn = 1'b0;
    gn = 1'b1;
    cyc(4);
    chk({doe, poe}, 2'b00);
    gn = 1'b0;
    cyc(4);
    chk({doe, poe}, 2'b11);
    $display("END freeze_gate");
    sa = 1'b1;
    cyc(3);
    chk({doe, poe}, 2'b11);
    cyc(1);
    chk({doe, poe}, 2'b00);
    cyc(2);
    chk({doe, poe, issue}, 3'b000);
    $display("END deselect");
    sa = 1'b0;
    for (r = 0; r < 2; r++) begin
      bw  = 4'($urandom);
      din = $urandom;
      pin = 4'($urandom);
      for (k = 0; k < 4; k++) m[8*k+:8] = {8{~bw[k]}};
      exp = {din & m, pin & ~bw, bw};
      rdy = 1'b0;
      wn  = 1'b0;
      for (i = 0; i < 80 && stall !== 1'b1; i++) begin
        @(negedge clk_sys_i);
        if (i > 4) chk(doe, 1'b0);
      end
      chk(stall, 1'b1);
      wn = 1'b1;
      idle = 0;
      popped = 0;
      for (i = 0; i < 400 && idle < 8; i++) begin
        @(negedge clk_sys_i);
        rdy = 1'($urandom);
        if (wval === 1'b1) begin
          idle = 0;
          if (rdy) begin
            popped++;
            chk(wword, exp);
          end
        end else idle++;
      end
      if (i == 400) timeout();
      chk(popped >= 16, 1'b1);
      chk(wval, 1'b0);
    end
    $display("END write");
    finish_test();
  end
endmodule // tb
